// File: src/scpl_loader.sv
`timescale 1ns/1ps
// Summary of operation
// - Data falling while clock high starts transaction
// - Data rising while clock high stops transaction
// - Device address shifted in cycles one-eight
// - Cycle nine decodes address; respond on match
// - Function address cycles 10-17, decoded at 18
// - Data bytes MSB first, strobe after each
// - Data line ignored during all strobe cycles
// - Own device address is 1011 0100
// - Function 00 caption, 03 control register
// - Every write carries exactly four bytes
// - Both fields: upper caption half feeds 284
// - Lower caption half feeds 21 or 284
// - Preset pins low: serial sets everything
// - Preset 01 forces control 09080209
// - Preset 10 forces control 1C080209
// - Preset 11 forces control 11080209
// - Control reads 0 and is flagged invalid until first write or preset
// - Preset mode overrides serial control writes
module scpl_loader import scpl_pkg::*; (
	input  wire logic    mclk_in,
	input  wire logic    sys_rst_in,
	input  wire logic    serial_clock_in,
	input  wire logic    serial_data_line_in,
	input  wire logic    mode_select_pin_low_in,
	input  wire logic    mode_select_pin_high_in,
	output logic [31:0]  caption_data_out,
	output logic [31:0]  encoder_control_out,
	output logic         control_valid_out,
	output scpl_caption_s caption_lines_out,
	output logic         output_black_out,
	output logic         caption_write_out,
	output logic         control_write_out,
	output logic         busy_out
);

	logic [3:0]   pin_raw;
	logic [3:0]   sync1_q;
	logic [3:0]   sync2_q;
	logic [3:0]   sync3_q;
	logic [3:0]   filt_d;
	logic [3:0]   filt_q;
	logic [3:0]   prev_q;
	logic         scl;
	logic         sda;
	logic [1:0]   mode;
	logic         scl_rise;
	logic         start_det;
	logic         stop_det;
	logic         bit_edge;
	scpl_state_e  state_q;
	scpl_target_e target_q;
	logic [5:0]   cyc_q;
	logic [3:0]   slot_q;
	logic [1:0]   byte_q;
	logic [7:0]   shift_q;
	logic [31:0]  data_q;
	logic         commit;
	logic         commit_ctl;
	logic         commit_cap;
	logic         en21;
	logic         en284;

	assign pin_raw = {mode_select_pin_high_in, mode_select_pin_low_in, serial_data_line_in, serial_clock_in};

	// Three-stage synchroniser; a level is taken once stages two and three agree
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sync1_q <= PIN_IDLE;
			sync2_q <= PIN_IDLE;
			sync3_q <= PIN_IDLE;
			filt_q  <= PIN_IDLE;
			prev_q  <= PIN_IDLE;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
			prev_q  <= filt_q;
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_filt
		assign filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync2_q[i] : filt_q[i];
	end

	assign scl  = filt_q[0];
	assign sda  = filt_q[1];
	assign mode = filt_q[3:2];

	assign scl_rise  = scl & ~prev_q[0];
	assign start_det = scl & prev_q[0] & prev_q[1] & ~sda;
	assign stop_det  = scl & prev_q[0] & ~prev_q[1] & sda;
	assign bit_edge  = scl_rise & ~start_det & ~stop_det;

	// Commit on the strobe of the fourth byte, which is cycle 54
	assign commit     = bit_edge && (state_q == ST_DATA) && (slot_q == SLOT_STROBE) && (byte_q == LAST_BYTE);
	assign commit_cap = commit && (target_q == TGT_CAPTION);
	assign commit_ctl = commit && (target_q == TGT_CONTROL) && (mode == MODE_SERIAL);

	// Transaction framing
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state_q  <= ST_IDLE;
			target_q <= TGT_CAPTION;
			cyc_q    <= CYC_START;
			slot_q   <= SLOT_RESET;
			byte_q   <= BYTE_RESET;
		end else if (start_det) begin
			state_q <= ST_DEV;
			cyc_q   <= CYC_START;
			slot_q  <= SLOT_RESET;
			byte_q  <= BYTE_RESET;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
		end else if (scl_rise && state_q != ST_IDLE) begin
			if (cyc_q != CYC_MAX) begin
				cyc_q <= cyc_q + 6'h01;
			end
			slot_q <= (slot_q == SLOT_STROBE) ? SLOT_RESET : slot_q + 4'h1;
			case (state_q)
				ST_DEV: begin
					if (slot_q == SLOT_STROBE) begin
						state_q <= (shift_q == DEV_ADDR) ? ST_FUNC : ST_SKIP;
					end
				end
				ST_FUNC: begin
					if (slot_q == SLOT_STROBE) begin
						if (shift_q == FUNC_CAPTION) begin
							state_q  <= ST_DATA;
							target_q <= TGT_CAPTION;
						end else if (shift_q == FUNC_CONTROL) begin
							state_q  <= ST_DATA;
							target_q <= TGT_CONTROL;
						end else begin
							state_q <= ST_SKIP;
						end
					end
				end
				ST_DATA: begin
					if (slot_q == SLOT_STROBE) begin
						byte_q <= byte_q + 2'h1;
						if (byte_q == LAST_BYTE) begin
							state_q <= ST_SKIP;
						end
					end
				end
				default: begin
					state_q <= ST_SKIP;
				end
			endcase
		end
	end

	// Shifting of address and data bits; strobe cycles leave them untouched
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			shift_q <= 8'h00;
			data_q  <= CAPTION_RESET;
		end else if (start_det) begin
			shift_q <= 8'h00;
		end else if (bit_edge && slot_q != SLOT_STROBE) begin
			if (state_q == ST_DEV || state_q == ST_FUNC) begin
				shift_q <= {shift_q[6:0], sda};
			end
			if (state_q == ST_DATA) begin
				data_q <= {data_q[30:0], sda};
			end
		end
	end

	// Caption register
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			caption_data_out  <= CAPTION_RESET;
			caption_write_out <= 1'b0;
		end else begin
			caption_write_out <= commit_cap;
			if (commit_cap) begin
				caption_data_out <= data_q;
			end
		end
	end

	// Control register: presets force it, serial writes load it in serial mode
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			encoder_control_out <= CONTROL_RESET;
			control_valid_out   <= 1'b0;
			control_write_out   <= 1'b0;
		end else begin
			control_write_out <= commit_ctl;
			case (mode)
				MODE_MASTER: begin
					encoder_control_out <= PRESET_MASTER;
					control_valid_out   <= 1'b1;
				end
				MODE_EMBEDDED: begin
					encoder_control_out <= PRESET_EMBEDDED;
					control_valid_out   <= 1'b1;
				end
				MODE_EXT_SYNC: begin
					encoder_control_out <= PRESET_EXT_SYNC;
					control_valid_out   <= 1'b1;
				end
				default: begin
					if (commit_ctl) begin
						encoder_control_out <= data_q;
						control_valid_out   <= 1'b1;
					end
				end
			endcase
		end
	end

	assign en21  = encoder_control_out[FIRST_FIELD_CAPTION_BIT];
	assign en284 = encoder_control_out[SECOND_FIELD_CAPTION_BIT];

	// Caption routing to the two field lines
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			caption_lines_out <= '0;
			output_black_out  <= 1'b0;
			busy_out          <= 1'b0;
		end else begin
			caption_lines_out.line21 <= en21 ? caption_data_out[15:0] : 16'h0000;
			if (en21 && en284) begin
				caption_lines_out.line284 <= caption_data_out[31:16];
			end else if (en284) begin
				caption_lines_out.line284 <= caption_data_out[15:0];
			end else begin
				caption_lines_out.line284 <= 16'h0000;
			end
			output_black_out <= encoder_control_out[OUTPUT_BLACK_BIT];
			busy_out         <= (state_q != ST_IDLE);
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	start_detect_a: assert property (start_det |=> state_q == ST_DEV && cyc_q == CYC_START)
		else $error("start did not open a transaction");

	stop_detect_a: assert property (stop_det && !start_det |=> state_q == ST_IDLE)
		else $error("stop did not close the transaction");

	dev_shift_a: assert property (bit_edge && state_q == ST_DEV && slot_q != SLOT_STROBE
		|=> shift_q[0] == $past(sda) && shift_q[7:1] == $past(shift_q[6:0]))
		else $error("device address bit not shifted");

	dev_mismatch_a: assert property (bit_edge && state_q == ST_DEV && slot_q == SLOT_STROBE
		&& shift_q != DEV_ADDR |=> state_q == ST_SKIP)
		else $error("foreign device address accepted");

	dev_match_a: assert property (bit_edge && state_q == ST_DEV && slot_q == SLOT_STROBE
		&& shift_q == DEV_ADDR |=> state_q == ST_FUNC)
		else $error("own device address rejected");

	func_select_a: assert property (bit_edge && state_q == ST_FUNC && slot_q == SLOT_STROBE
		&& shift_q == FUNC_CONTROL |=> state_q == ST_DATA && target_q == TGT_CONTROL)
		else $error("control function not selected");

	func_caption_a: assert property (bit_edge && state_q == ST_FUNC && slot_q == SLOT_STROBE
		&& shift_q == FUNC_CAPTION |=> state_q == ST_DATA && target_q == TGT_CAPTION)
		else $error("caption function not selected");

	func_refuse_a: assert property (bit_edge && state_q == ST_FUNC && slot_q == SLOT_STROBE
		&& shift_q != FUNC_CAPTION && shift_q != FUNC_CONTROL |=> state_q == ST_SKIP)
		else $error("unknown function address accepted");

	data_msb_a: assert property (bit_edge && state_q == ST_DATA && slot_q != SLOT_STROBE
		|=> data_q[0] == $past(sda) && data_q[31:1] == $past(data_q[30:0]))
		else $error("data bit not shifted msb first");

	byte_count_a: assert property (bit_edge && state_q == ST_DATA && slot_q == SLOT_STROBE
		|=> byte_q == $past(byte_q) + 2'h1)
		else $error("byte counter did not advance on strobe");

	strobe_ignore_a: assert property (bit_edge && slot_q == SLOT_STROBE
		|=> $stable(data_q) && $stable(shift_q))
		else $error("data line sampled on a strobe cycle");

	commit_cycle_a: assert property (commit |-> cyc_q == CYC_LAST - 6'h01 ##1 cyc_q == CYC_LAST)
		else $error("register committed off cycle 54");

	control_load_a: assert property (commit_ctl
		|=> encoder_control_out == $past(data_q) ##1 control_write_out == 1'b0)
		else $error("control register not loaded after four bytes");

	write_pulse_a: assert property (control_write_out |=> !control_write_out)
		else $error("control write pulse longer than one cycle");

	caption_load_a: assert property (commit_cap |=> caption_data_out == $past(data_q) && caption_write_out)
		else $error("caption register not loaded after four bytes");

	caption_hold_a: assert property (!commit_cap |=> $stable(caption_data_out))
		else $error("caption register changed without a full write");

	no_partial_a: assert property (!commit_ctl && mode == MODE_SERIAL && $past(mode) == MODE_SERIAL
		|=> $stable(encoder_control_out))
		else $error("control register changed without a full write");

	valid_hold_a: assert property (control_valid_out |=> control_valid_out)
		else $error("control valid flag dropped");

	preset_master_a: assert property (mode == MODE_MASTER |=> encoder_control_out == PRESET_MASTER)
		else $error("master preset not applied");

	preset_embedded_a: assert property (mode == MODE_EMBEDDED |=> encoder_control_out == PRESET_EMBEDDED)
		else $error("embedded preset not applied");

	preset_ext_a: assert property (mode == MODE_EXT_SYNC |=> encoder_control_out == PRESET_EXT_SYNC)
		else $error("external sync preset not applied");

	preset_priority_a: assert property (mode != MODE_SERIAL |=> !control_write_out)
		else $error("serial control write taken in preset mode");

	preset_valid_a: assert property (mode != MODE_SERIAL |=> control_valid_out)
		else $error("preset mode left control register invalid");

	both_fields_a: assert property (en21 && en284
		|=> caption_lines_out.line284 == $past(caption_data_out[31:16]))
		else $error("second field not fed from upper caption half");

	first_field_a: assert property (en21 |=> caption_lines_out.line21 == $past(caption_data_out[15:0]))
		else $error("first field not fed from lower caption half");

	second_field_a: assert property (!en21 && en284
		|=> caption_lines_out.line284 == $past(caption_data_out[15:0]))
		else $error("second field alone not fed from lower caption half");

	field_off_a: assert property (!en21 |=> caption_lines_out.line21 == 16'h0000)
		else $error("disabled first field carries caption data");

	caption_commit_c: cover property (commit_cap);
	control_commit_c: cover property (commit_ctl);
	foreign_addr_c: cover property (bit_edge && state_q == ST_DEV && slot_q == SLOT_STROBE && shift_q != DEV_ADDR);
	preset_ext_c: cover property (mode == MODE_EXT_SYNC ##1 mode == MODE_SERIAL);
	partial_frame_c: cover property (stop_det && state_q == ST_DATA);

endmodule

// File: src/scpl_pkg.sv
package scpl_pkg;

	// Two-wire framing
	localparam logic [7:0] DEV_ADDR       = 8'hB4;
	localparam logic [7:0] FUNC_CAPTION   = 8'h00;
	localparam logic [7:0] FUNC_CONTROL   = 8'h03;
	localparam logic [3:0] SLOT_STROBE    = 4'h8;
	localparam logic [1:0] LAST_BYTE      = 2'h3;
	localparam logic [5:0] CYC_LAST       = 6'h36;
	localparam logic [5:0] CYC_MAX        = 6'h3F;
	localparam logic [5:0] CYC_START      = 6'h00;

	// Preset pin modes, {high pin, low pin}
	localparam logic [1:0] MODE_SERIAL    = 2'h0;
	localparam logic [1:0] MODE_MASTER    = 2'h1;
	localparam logic [1:0] MODE_EMBEDDED  = 2'h2;
	localparam logic [1:0] MODE_EXT_SYNC  = 2'h3;

	localparam logic [31:0] PRESET_MASTER   = 32'h09080209;
	localparam logic [31:0] PRESET_EMBEDDED = 32'h1C080209;
	localparam logic [31:0] PRESET_EXT_SYNC = 32'h11080209;

	// Control register field positions
	localparam int FIRST_FIELD_CAPTION_BIT  = 19;
	localparam int SECOND_FIELD_CAPTION_BIT = 18;
	localparam int OUTPUT_BLACK_BIT         = 30;

	// Reset values
	localparam logic [31:0] CAPTION_RESET = 32'h00000000;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam logic [3:0]  PIN_IDLE      = 4'h3;
	localparam logic [3:0]  SLOT_RESET    = 4'h0;
	localparam logic [1:0]  BYTE_RESET    = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_FUNC,
		ST_DATA,
		ST_SKIP
	} scpl_state_e;

	typedef enum logic {
		TGT_CAPTION,
		TGT_CONTROL
	} scpl_target_e;

	typedef struct packed {
		logic [15:0] line21;
		logic [15:0] line284;
	} scpl_caption_s;

endpackage

// File: verification/scpl_host.sv
`timescale 1ns/1ps
module scpl_host (
	input  wire logic clk_in,
	output logic      scl_out,
	output logic      sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	// Quarter of the 160 ns link period
	task automatic wait_q();
		repeat (8) @(negedge clk_in);
	endtask

	// Data changes only while the clock is low
	task automatic put_bit(input logic b);
		sda_out = b;
		wait_q();
		scl_out = 1'b1;
		wait_q();
		wait_q();
		scl_out = 1'b0;
		wait_q();
	endtask

	task automatic xfer(input logic [7:0] dev, input logic [7:0] func, input logic [31:0] data, input int nbytes);
		logic [47:0] bits;
		bits = {dev, func, data};
		sda_out = 1'b0;
		wait_q();
		scl_out = 1'b0;
		wait_q();
		for (int g = 0; g < 2 + nbytes; g++) begin
			for (int j = 0; j < 8; j++) begin
				put_bit(bits[47 - 8 * g - j]);
			end
			// Strobe slot carries a deliberately flipped level
			put_bit(~sda_out);
		end
		sda_out = 1'b0;
		wait_q();
		scl_out = 1'b1;
		wait_q();
		sda_out = 1'b1;
		wait_q();
		wait_q();
	endtask
endmodule

// File: verification/scpl_loader_bench.sv
`timescale 1ns/1ps
module scpl_loader_bench;
	import scpl_pkg::*;
	logic          mclk_in = 1'b0;
	logic          sys_rst_in = 1'b1;
	logic          scl;
	logic          sda;
	logic          pin_lo = 1'b0;
	logic          pin_hi = 1'b0;
	logic [31:0]   cap_out;
	logic [31:0]   ctl_out;
	logic          valid_out;
	scpl_caption_s lines_out;
	logic          black_out;
	logic          cap_wr;
	logic          ctl_wr;
	logic          busy_out;
	int            errors = 0;
	int            checks_done = 0;
	int            cycles = 0;
	int            cap_p = 0;
	int            ctl_p = 0;
	int            exp_cap_p = 0;
	int            exp_ctl_p = 0;
	logic [31:0]   m_cap = 32'h0;
	logic [31:0]   m_ctl = 32'h0;
	logic          m_valid = 1'b0;
	logic [15:0]   seed = 16'h617D;
	logic [31:0]   pv [4] = '{32'h0, 32'h09080209, 32'h1C080209, 32'h11080209};
	logic [7:0]    bad_dev [4] = '{8'hB5, 8'hB4, 8'hB4, 8'hB4};
	logic [7:0]    bad_fn [4] = '{8'h00, 8'h01, 8'h00, 8'h03};
	int            bad_n [4] = '{4, 4, 3, 2};

	always #2.5 mclk_in = ~mclk_in;

	scpl_host i_scpl_host (.clk_in(mclk_in), .scl_out(scl), .sda_out(sda));

	scpl_loader i_scpl_loader (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .serial_clock_in(scl), .serial_data_line_in(sda),
		.mode_select_pin_low_in(pin_lo), .mode_select_pin_high_in(pin_hi), .caption_data_out(cap_out),
		.encoder_control_out(ctl_out), .control_valid_out(valid_out), .caption_lines_out(lines_out),
		.output_black_out(black_out), .caption_write_out(cap_wr), .control_write_out(ctl_wr),
		.busy_out(busy_out));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] rnd32();
		seed = lfsr(seed);
		rnd32[31:16] = seed;
		seed = lfsr(seed);
		rnd32[15:0] = seed;
	endfunction

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cap_wr === 1'b1)
			cap_p++;
		if (ctl_wr === 1'b1)
			ctl_p++;
		if (cycles == 60000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic compare_all();
		logic [15:0] l21;
		logic [15:0] l284;
		l21 = m_ctl[19] ? m_cap[15:0] : 16'h0;
		l284 = m_ctl[18] ? (m_ctl[19] ? m_cap[31:16] : m_cap[15:0]) : 16'h0;
		check(cap_out, m_cap);
		check(valid_out, m_valid);
		// No control value is assumed before the first write or preset
		if (m_valid) begin
			check(ctl_out, m_ctl);
			check({lines_out.line21, lines_out.line284}, {l21, l284});
			check(black_out, m_ctl[30]);
		end
		check(cap_p, exp_cap_p);
		check(ctl_p, exp_ctl_p);
		check(busy_out, 1'b0);
	endtask

	task automatic frame(input logic [7:0] dev, input logic [7:0] fn, input logic [31:0] d, input int n);
		i_scpl_host.xfer(dev, fn, d, n);
		repeat (10) @(negedge mclk_in);
		if (dev == 8'hB4 && n == 4 && fn == 8'h00) begin
			m_cap = d;
			exp_cap_p++;
		end
		if (dev == 8'hB4 && n == 4 && fn == 8'h03 && {pin_hi, pin_lo} == 2'h0) begin
			m_ctl = d;
			m_valid = 1'b1;
			exp_ctl_p++;
		end
		compare_all();
	endtask

	initial begin
		repeat (5) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		repeat (6) @(negedge mclk_in);
		compare_all();
		for (int k = 0; k < 4; k++) begin
			frame(8'hB4, 8'h03, {rnd32() & 32'hFFF3FFFF} | (k << 18), 4);
			frame(8'hB4, 8'h00, rnd32(), 4);
		end
		$display("test serial writes done");
		for (int k = 0; k < 4; k++)
			frame(bad_dev[k], bad_fn[k], rnd32(), bad_n[k]);
		$display("test refused frames done");
		for (int m = 1; m < 4; m++) begin
			{pin_hi, pin_lo} = m[1:0];
			repeat (10) @(negedge mclk_in);
			m_ctl = pv[m];
			m_valid = 1'b1;
			compare_all();
			frame(8'hB4, 8'h03, rnd32(), 4);
			frame(8'hB4, 8'h00, rnd32(), 4);
		end
		{pin_hi, pin_lo} = 2'h0;
		repeat (10) @(negedge mclk_in);
		compare_all();
		frame(8'hB4, 8'h03, rnd32() & 32'hBFFFFFFF, 4);
		$display("test preset modes done");
		end_of_test();
	end
endmodule
